// *** design/ltpm_pkg.sv ***
// package for the logical to physical mapper: offsets, fields, resets
//
// Behaviour
// R1: the region of a memory access is chosen by comparing logical bits 15:10 with the boundaries.
// R2: region n (n>=1) starts at (boundary+1)*1 KB and ends below the next start; region zero starts at 0.
// R3: physical bits 19:10 are region base plus logical bits 15:10; bits 9:0 pass unchanged.
// R4: region zero has boundary zero and base zero, so logical 0000H-03FFH maps to 00000H-003FFH.
// R5: every CPU memory-space access (fetch, data, restart fetch, vector table read) is translated.
// R6: CPU I/O cycles output the logical address untranslated with zeros on bits 19:16.
// R7: DMA addresses bypass translation and reach the bus as issued.
// R8: reset sets boundaries 1-4 to 3FH, bases 1-3 to 000H, base 4 fixed at 3C0H.
// R9: after reset only region zero is active, mapping 64 KB one-to-one onto the lowest 64 KB.
// R10: with non-increasing boundaries the higher-numbered region wins and the lower vanishes.
// R11: a written mapping value takes effect from the bus cycle after the I/O write.
// R12: the mapping registers decode at I/O 00H-07H and 08H-0FH is reserved; others must not use them.
// R13: software should keep boundaries below 3FH; 3FH makes that region absent.
// R14: combined registers hold base bits 1:0 in bits 7:6 and boundary in 5:0; base registers hold base 9:2.
// R15: bits 7:6 of the fourth combined register read zero and ignore writes; fourth base reads F0H.
// R16: an address goes to the highest valid region whose boundary is below logical bits 15:10, else region zero.
package ltpm_pkg;
  localparam int LTPM_REGIONS = 4;
  localparam logic [7:0] LTPM_OFS_R1_BB = 8'h00;
  localparam logic [7:0] LTPM_OFS_R1_BH = 8'h01;
  localparam logic [7:0] LTPM_OFS_R2_BB = 8'h02;
  localparam logic [7:0] LTPM_OFS_R2_BH = 8'h03;
  localparam logic [7:0] LTPM_OFS_R3_BB = 8'h04;
  localparam logic [7:0] LTPM_OFS_R3_BH = 8'h05;
  localparam logic [7:0] LTPM_OFS_R4_BB = 8'h06;
  localparam logic [7:0] LTPM_OFS_R4_BH = 8'h07;
  localparam logic [7:0] LTPM_RSV_LAST = 8'h0F;
  localparam logic [7:0] LTPM_DEC_MASK = 8'hF0;
  localparam int LTPM_BOUND_LSB = 0;
  localparam int LTPM_BOUND_W = 6;
  localparam int LTPM_BASELO_LSB = 6;
  localparam int LTPM_BASE_W = 10;
  localparam logic [5:0] LTPM_BOUND_RST = 6'h3F;
  localparam logic [5:0] LTPM_BOUND_INVALID = 6'h3F;
  localparam logic [9:0] LTPM_BASE_RST = 10'h000;
  localparam logic [9:0] LTPM_BASE4_FIXED = 10'h3C0;
  localparam logic [5:0] LTPM_BOUND0 = 6'h00;
  localparam logic [9:0] LTPM_BASE0 = 10'h000;
  localparam logic [3:0] LTPM_IO_UPPER = 4'h0;
  typedef enum logic [1:0] {LTPM_CYC_MEM, LTPM_CYC_IO, LTPM_CYC_DMA} ltpm_cyc_t;
endpackage : ltpm_pkg

// *** design/ltpm_map_if.sv ***
// interface carrying the mapping table from the register file to the translator
`timescale 1ns/1ps
`default_nettype none
interface ltpm_map_if;
  logic [5:0] bound [1:4];
  logic [9:0] base [1:4];
  modport regs (output bound, output base);
  modport xlat (input bound, input base);
endinterface : ltpm_map_if
`default_nettype wire

// *** design/ltpm_xlat.sv ***
// combinational region select and physical address adder
`timescale 1ns/1ps
`default_nettype none
module ltpm_xlat
  import ltpm_pkg::*;
(
  // mapping table
  ltpm_map_if.xlat map,
  // logical address
  input wire logic [15:0] logical_in,
  // results
  output logic [19:0] physical_out,
  output logic [2:0] region_out
);
  logic [5:0] page;
  logic [9:0] sel_base;
  assign page = logical_in[15:10];

  always_comb begin
    // region zero unless a later valid region claims the page; later wins
    sel_base = LTPM_BASE0; // see R4
    region_out = 3'h0;
    for (int n = 1; n <= LTPM_REGIONS; n++) begin
      // 3FH boundary never satisfies bound<page, region absent
      if (map.bound[n] != LTPM_BOUND_INVALID && map.bound[n] < page) begin // see R1
        sel_base = map.base[n]; // see R16
        region_out = 3'(n); // see R10
      end
    end
    // see R2
    physical_out = {10'(sel_base + {4'h0, page}), logical_in[9:0]}; // see R3
  end
endmodule : ltpm_xlat
`default_nettype wire

// *** design/ltpm_top.sv ***
// logical to physical mapper: mapping registers on the internal I/O bus and address path
`timescale 1ns/1ps
`default_nettype none
module ltpm_top
  import ltpm_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // cpu bus cycle start, one per bus cycle
  input wire logic cyc_start_in,
  input wire logic cyc_io_in,
  input wire logic cyc_dma_in,
  input wire logic [15:0] addr_in,
  input wire logic [19:0] dma_addr_in,
  // i/o write and read strobes with data
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  // outputs
  output logic [19:0] phys_addr_out,
  output logic phys_valid_out,
  output logic [2:0] region_out,
  output logic [7:0] io_rdata_out,
  output logic io_hit_out
);
  logic [5:0] bound_q [1:4];
  logic [5:0] bound_d [1:4];
  logic [9:0] base_q [1:4];
  logic [9:0] base_d [1:4];
  logic [19:0] addr_q, addr_d;
  logic valid_q, valid_d;
  logic [2:0] reg_q, reg_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic [19:0] xl_phys;
  logic [2:0] xl_reg;
  logic [7:0] io_a;
  logic io_ours;

  ltpm_map_if map ();
  ltpm_xlat u_xlat (
    .map(map),
    .logical_in(addr_in),
    .physical_out(xl_phys),
    .region_out(xl_reg)
  );

  genvar g;
  generate
    for (g = 1; g <= LTPM_REGIONS; g++) begin : g_map
      assign map.bound[g] = bound_q[g];
      assign map.base[g] = base_q[g];
    end
  endgenerate

  assign io_a = addr_in[7:0];
  // only low byte decoded; upper byte of an i/o address is ignored
  // dma cycles never touch the table even if the io flag is also up
  assign io_ours = cyc_start_in && cyc_io_in && !cyc_dma_in
    && ((io_a & LTPM_DEC_MASK) == 8'h00); // see R12

  // mapping registers
  always_comb begin
    for (int n = 1; n <= LTPM_REGIONS; n++) begin
      bound_d[n] = bound_q[n];
      base_d[n] = base_q[n];
    end
    if (reset_in) begin
      for (int n = 1; n <= LTPM_REGIONS; n++) begin
        bound_d[n] = LTPM_BOUND_RST; // see R8
        base_d[n] = (n == LTPM_REGIONS) ? LTPM_BASE4_FIXED : LTPM_BASE_RST; // see R8
      end
    end else if (io_ours && io_wr_in) begin
      for (int n = 1; n < LTPM_REGIONS; n++) begin
        if (io_a == 8'(2 * (n - 1))) begin
          bound_d[n] = io_wdata_in[LTPM_BOUND_W-1:LTPM_BOUND_LSB]; // see R14
          base_d[n][1:0] = io_wdata_in[7:LTPM_BASELO_LSB]; // see R14
        end
        if (io_a == 8'(2 * n - 1)) begin
          base_d[n][9:2] = io_wdata_in; // see R14
        end
      end
      // fourth region: boundary only, base fixed
      if (io_a == LTPM_OFS_R4_BB) begin
        bound_d[LTPM_REGIONS] = io_wdata_in[LTPM_BOUND_W-1:LTPM_BOUND_LSB]; // see R15
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    for (int n = 1; n <= LTPM_REGIONS; n++) begin
      bound_q[n] <= bound_d[n];
      base_q[n] <= base_d[n];
    end
  end

  // register read mux
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      LTPM_OFS_R1_BB: v = {base_q[1][1:0], bound_q[1]};
      LTPM_OFS_R1_BH: v = base_q[1][9:2];
      LTPM_OFS_R2_BB: v = {base_q[2][1:0], bound_q[2]};
      LTPM_OFS_R2_BH: v = base_q[2][9:2];
      LTPM_OFS_R3_BB: v = {base_q[3][1:0], bound_q[3]};
      LTPM_OFS_R3_BH: v = base_q[3][9:2];
      LTPM_OFS_R4_BB: v = {2'h0, bound_q[4]}; // see R15
      LTPM_OFS_R4_BH: v = LTPM_BASE4_FIXED[9:2]; // see R15
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  // address path, one registered stage per bus cycle; a write in cycle k
  // lands in bound_q at the edge that also registers cycle k, so cycle k+1
  // sees the new value
  always_comb begin
    addr_d = addr_q;
    valid_d = 1'b0;
    reg_d = reg_q;
    rdata_d = rdata_q;
    hit_d = 1'b0;
    if (reset_in) begin
      addr_d = 20'h00000;
      reg_d = 3'h0;
      rdata_d = 8'h00;
    end else if (cyc_start_in) begin
      valid_d = 1'b1;
      if (cyc_dma_in) begin
        addr_d = dma_addr_in; // see R7
        reg_d = 3'h0;
      end else if (cyc_io_in) begin
        addr_d = {LTPM_IO_UPPER, addr_in}; // see R6
        reg_d = 3'h0;
        if (io_ours) begin
          hit_d = 1'b1;
          if (io_rd_in) begin
            rdata_d = rd_mux(io_a);
          end
        end
      end else begin
        addr_d = xl_phys; // see R5
        reg_d = xl_reg; // see R11
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    addr_q <= addr_d;
    valid_q <= valid_d;
    reg_q <= reg_d;
    rdata_q <= rdata_d;
    hit_q <= hit_d;
  end

  assign phys_addr_out = addr_q;
  assign phys_valid_out = valid_q;
  assign region_out = reg_q;
  assign io_rdata_out = rdata_q;
  assign io_hit_out = hit_q;

  // checks
  AST_LOW_PAGE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R4
    cyc_start_in && !cyc_io_in && !cyc_dma_in && addr_in[15:10] == 6'h00
    |=> phys_addr_out == {10'h000, $past(addr_in[9:0])})
    else $error("low page not identity mapped");
  AST_IO_UPPER: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R6
    cyc_start_in && cyc_io_in && !cyc_dma_in
    |=> phys_addr_out == {4'h0, $past(addr_in)})
    else $error("io address altered");
  AST_DMA_PASS: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R7
    cyc_start_in && cyc_dma_in |=> phys_addr_out == $past(dma_addr_in))
    else $error("dma address altered");
  AST_RESET_MAP: assert property (@(posedge core_clk_in) // see R8
    reset_in |=> bound_q[1] == 6'h3F && bound_q[4] == 6'h3F && base_q[2] == 10'h000
    && base_q[4] == 10'h3C0)
    else $error("reset values wrong");
  AST_INVALID_GONE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R13
    xl_reg != 3'h0 |-> map.bound[xl_reg] != 6'h3F)
    else $error("invalid region selected");
  AST_REGION_SEL: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R16
    xl_reg != 3'h0 |-> map.bound[xl_reg] < addr_in[15:10])
    else $error("region above its start");
  AST_FIXED_BASE4: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R15
    base_q[4] == 10'h3C0)
    else $error("fixed base changed");
  AST_WRITE_NEXT: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R11
    io_ours && io_wr_in && io_a == 8'h00 |=> bound_q[1] == $past(io_wdata_in[5:0]))
    else $error("write not visible next cycle");
  AST_ADD: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R3
    cyc_start_in && !cyc_io_in && !cyc_dma_in
    |=> phys_addr_out[9:0] == $past(addr_in[9:0]))
    else $error("low bits changed");

  // bus cycle framing
  AST_VALID_PULSE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R5
    cyc_start_in
    |=> phys_valid_out)
    else $error("bus cycle not answered");

  AST_VALID_IDLE: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R5
    !cyc_start_in
    |=> !phys_valid_out)
    else $error("valid without bus cycle");

  AST_MEM_REGION: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R5
    cyc_start_in && !cyc_io_in && !cyc_dma_in
    |=> region_out == $past(xl_reg))
    else $error("region not registered");

  AST_IO_REGION: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R6
    cyc_start_in && cyc_io_in && !cyc_dma_in
    |=> region_out == 3'h0)
    else $error("io cycle shows a region");

  AST_IO_TOP_ZERO: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R6
    cyc_start_in && cyc_io_in && !cyc_dma_in
    |=> phys_addr_out[19:16] == 4'h0)
    else $error("io upper bits not zero");

  AST_DMA_REGION: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R7
    cyc_start_in && cyc_dma_in
    |=> region_out == 3'h0 && !io_hit_out)
    else $error("dma cycle treated as mapped");

  // i/o decode of the mapping registers
  AST_HIT_OURS: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R12
    cyc_start_in && cyc_io_in && !cyc_dma_in && addr_in[7:4] == 4'h0
    |=> io_hit_out)
    else $error("own i/o address missed");

  AST_HIT_OTHER: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R12
    cyc_start_in && cyc_io_in && addr_in[7:4] != 4'h0
    |=> !io_hit_out)
    else $error("foreign i/o address claimed");

  AST_MEM_NO_HIT: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R5
    cyc_start_in && !cyc_io_in
    |=> !io_hit_out)
    else $error("memory cycle claimed as i/o");

  AST_RD_BB1: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R14
    io_ours && io_rd_in && io_a == LTPM_OFS_R1_BB
    |=> io_rdata_out == {$past(base_q[1][1:0]), $past(bound_q[1])})
    else $error("combined register read wrong");

  AST_RD_BB4_TOP: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R15
    io_ours && io_rd_in && io_a == LTPM_OFS_R4_BB
    |=> io_rdata_out[7:6] == 2'h0)
    else $error("fourth combined top bits not zero");

  AST_RD_BH4: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R15
    io_ours && io_rd_in && io_a == LTPM_OFS_R4_BH
    |=> io_rdata_out == 8'hF0)
    else $error("fourth base register read wrong");

  AST_RD_RSV: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R12
    io_ours && io_rd_in && io_a[7:3] == 5'h01
    |=> io_rdata_out == 8'h00)
    else $error("reserved address read not zero");

  // table updates
  AST_WR_BASE_HI: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R14
    io_ours && io_wr_in && io_a == LTPM_OFS_R1_BH
    |=> base_q[1][9:2] == $past(io_wdata_in))
    else $error("base high byte not stored");

  AST_WR_BASE_LO: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R14
    io_ours && io_wr_in && io_a == LTPM_OFS_R1_BB
    |=> base_q[1][1:0] == $past(io_wdata_in[7:6]))
    else $error("base low bits not stored");

  AST_WR_RSV_KEEP: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R12
    io_ours && io_wr_in && io_a[3:0] >= 4'h7
    |=> bound_q[4] == $past(bound_q[4]) && base_q[3] == $past(base_q[3]))
    else $error("reserved write changed the table");

  AST_NO_WRITE_KEEP: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R11
    !(io_ours && io_wr_in)
    |=> bound_q[1] == $past(bound_q[1]) && bound_q[2] == $past(bound_q[2]))
    else $error("table changed without a write");

  // region choice
  AST_REGION_TOP: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R10
    bound_q[4] != 6'h3F && bound_q[4] < addr_in[15:10]
    |-> xl_reg == 3'h4)
    else $error("highest region not preferred");

  AST_INVALID4: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R13
    bound_q[4] == 6'h3F
    |-> xl_reg != 3'h4)
    else $error("absent region selected");

  AST_PAGE0_REGION: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R4
    addr_in[15:10] == 6'h00
    |-> xl_reg == 3'h0)
    else $error("lowest page left region zero");

  AST_BASE4_ADD: assert property (@(posedge core_clk_in) disable iff (reset_in) // see R3
    cyc_start_in && !cyc_io_in && !cyc_dma_in && xl_reg == 3'h4
    |=> phys_addr_out[19:10] == 10'h3C0 + {4'h0, $past(addr_in[15:10])})
    else $error("fourth region sum wrong");

  // reset state
  AST_RESET_OUT: assert property (@(posedge core_clk_in) // see R8
    reset_in
    |=> phys_addr_out == 20'h00000 && region_out == 3'h0 && !phys_valid_out)
    else $error("outputs not cleared by reset");

  AST_RESET_REST: assert property (@(posedge core_clk_in) // see R8
    reset_in
    |=> bound_q[2] == 6'h3F && bound_q[3] == 6'h3F && base_q[1] == 10'h000 && base_q[3] == 10'h000)
    else $error("reset table values wrong");
endmodule : ltpm_top
`default_nettype wire

// *** bench/ltpm_cpu_model.sv ***
// cpu core model issuing memory, i/o and dma bus cycles
`timescale 1ns/1ps
`default_nettype none
module ltpm_cpu_model (
  // clock
  input wire logic core_clk_in,
  // bus cycle request
  output logic cyc_start_out,
  output logic cyc_io_out,
  output logic cyc_dma_out,
  output logic [15:0] addr_out,
  output logic [19:0] dma_addr_out,
  output logic io_wr_out,
  output logic io_rd_out,
  output logic [7:0] io_wdata_out
);
  initial begin
    {cyc_start_out, cyc_io_out, cyc_dma_out, io_wr_out, io_rd_out} = 5'h00;
    addr_out = 16'h0000;
    dma_addr_out = 20'h00000;
    io_wdata_out = 8'h00;
  end
  // one cycle over one rising edge; fields inverted after so stale values never match
  task automatic cycle(input logic io, dma, wr, rd, input logic [15:0] a,
                       input logic [19:0] d, input logic [7:0] w);
    @(negedge core_clk_in);
    {cyc_start_out, cyc_io_out, cyc_dma_out, io_wr_out, io_rd_out} = {1'b1, io, dma, wr, rd};
    addr_out = a;
    dma_addr_out = d;
    io_wdata_out = w;
    @(negedge core_clk_in);
    {cyc_start_out, io_wr_out, io_rd_out} = 3'h0;
    addr_out = ~a;
    dma_addr_out = ~d;
    io_wdata_out = ~w;
  endtask : cycle
endmodule : ltpm_cpu_model
`default_nettype wire

// *** bench/ltpm_tb_top.sv ***
// self-checking bench for the logical to physical mapper
`timescale 1ns/1ps
`default_nettype none
module ltpm_tb_top;
  import ltpm_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cs, cio, cdma, wr, rd;
  logic [15:0] addr;
  logic [19:0] daddr;
  logic [7:0] wd, rdata;
  logic [19:0] phys_addr_out;
  logic phys_valid_out, io_hit_out;
  logic [2:0] region_out;
  int failures = 0;
  int total_checks = 0;
  logic [5:0] bnd [0:4];
  logic [9:0] bas [0:4];
  logic [7:0] rv [0:15] = '{8'h3F, 8'h00, 8'h3F, 8'h00, 8'h3F, 8'h00, 8'h3F, 8'hF0,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #5 core_clk_in = ~core_clk_in;
  ltpm_cpu_model i_ltpm_cpu_model (.core_clk_in(core_clk_in), .cyc_start_out(cs),
    .cyc_io_out(cio), .cyc_dma_out(cdma), .addr_out(addr), .dma_addr_out(daddr),
    .io_wr_out(wr), .io_rd_out(rd), .io_wdata_out(wd));
  ltpm_top i_ltpm_top (.core_clk_in(core_clk_in), .reset_in(reset_in), .cyc_start_in(cs),
    .cyc_io_in(cio), .cyc_dma_in(cdma), .addr_in(addr), .dma_addr_in(daddr),
    .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wd), .phys_addr_out(phys_addr_out),
    .phys_valid_out(phys_valid_out), .region_out(region_out), .io_rdata_out(rdata),
    .io_hit_out(io_hit_out));
  task automatic conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic note(input logic ok, input string m);
    total_checks++;
    if (!ok) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : note
  task automatic chk_phys(input logic [19:0] g, e, input string m);
    note(g === e, m);
  endtask : chk_phys
  task automatic chk_byte(input logic [7:0] g, e, input string m);
    note(g === e, m);
  endtask : chk_byte
  task automatic chk_small(input logic [2:0] g, e, input string m);
    note(g === e, m);
  endtask : chk_small
  // expected {region, physical} from the bench's own copy of the table
  function automatic logic [22:0] xlate(input logic [15:0] a);
    logic [2:0] r;
    r = 3'd0;
    for (int n = 1; n <= 4; n++) begin
      if (bnd[n] != 6'h3F && bnd[n] < a[15:10]) r = 3'(n);
    end
    return {r, bas[r] + 10'(a[15:10]), a[9:0]};
  endfunction : xlate
  task automatic mem(input logic [15:0] a);
    logic [22:0] e;
    e = xlate(a);
    i_ltpm_cpu_model.cycle(1'b0, 1'b0, 1'b0, 1'b0, a, 20'h00000, 8'h00);
    chk_small({2'b00, phys_valid_out}, 3'h1, "valid");
    chk_phys(phys_addr_out, e[19:0], "phys");
    chk_small(region_out, e[22:20], "region");
  endtask : mem
  task automatic io_rd(input logic [15:0] a, input logic [7:0] e);
    i_ltpm_cpu_model.cycle(1'b1, 1'b0, 1'b0, 1'b1, a, 20'h00000, 8'h00);
    chk_small({2'b00, io_hit_out}, 3'(a[7:0] < 8'h10), "hit");
    chk_phys(phys_addr_out, {4'h0, a}, "io addr");
    if (a[7:0] < 8'h10) chk_byte(rdata, e, "rdata");
  endtask : io_rd
  task automatic io_wr(input logic [7:0] a, d);
    int n;
    n = int'(a[2:1]) + 1;
    i_ltpm_cpu_model.cycle(1'b1, 1'b0, 1'b1, 1'b0, {8'h00, a}, 20'h00000, d);
    if (a < 8'h06 && !a[0]) {bas[n][1:0], bnd[n]} = d;
    else if (a < 8'h06) bas[n][9:2] = d;
    else if (a == 8'h06) bnd[4] = d[5:0];
  endtask : io_wr
  initial begin
    for (int n = 0; n <= 4; n++) begin
      bnd[n] = (n == 0) ? 6'h00 : 6'h3F;
      bas[n] = (n == 4) ? 10'h3C0 : 10'h000;
    end
    repeat (12) @(negedge core_clk_in);
    reset_in = 1'b0;
    for (int i = 0; i < 16; i++) io_rd(16'(i), rv[i]);
    io_rd(16'h0010, 8'h00);
    mem(16'hFFFF);
    mem(16'h03FF);
    io_wr(8'h00, 8'h0F);
    io_wr(8'h01, 8'h20);
    io_wr(8'h02, 8'h1F);
    io_wr(8'h03, 8'h10);
    io_wr(8'h04, 8'h2F);
    io_wr(8'h05, 8'h30);
    io_wr(8'h06, 8'hF2);
    io_wr(8'h07, 8'h55);
    io_rd(16'h0006, 8'h32);
    io_rd(16'h0007, 8'hF0);
    io_rd(16'h0001, 8'h20);
    for (int p = 0; p < 64; p++) mem({6'(p), 10'h2A5});
    io_wr(8'h00, 8'h45);
    mem(16'h1800);
    io_wr(8'h00, 8'h25);
    mem(16'h9800);
    io_wr(8'h04, 8'h3F);
    mem(16'hC000);
    io_rd(16'hABCD, 8'h00);
    i_ltpm_cpu_model.cycle(1'b1, 1'b1, 1'b0, 1'b0, 16'h1234, 20'hFEDCB, 8'h00);
    chk_phys(phys_addr_out, 20'hFEDCB, "dma addr");
    chk_small(region_out, 3'h0, "dma region");
    conclude;
  end
  // whole run is under 2000 cycles
  initial begin
    #50000;
    failures++;
    conclude;
  end
endmodule : ltpm_tb_top
`default_nettype wire
